// >>> rtl/angle_scaler.v
`timescale 1ns/1ns
`include "encoder_regs_defs.vh"
// Zero-offset subtraction with a hold band at the wrap point
module angle_scaler (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Angle in and scaled angle out
    input  wire [11:0] raw_i,
    input  wire [11:0] offset_i,
    output reg  [11:0] scaled_o
);
    wire [11:0] diff = raw_i - offset_i;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scaled_o <= 12'h000;
        end else begin
            // Near the wrap, only jump across once past the band [R17]
            if (scaled_o > (`FULL_TURN_MAX - `WRAP_OUTPUT_HYSTERESIS_LSBS) && diff < `WRAP_OUTPUT_HYSTERESIS_LSBS) begin
                scaled_o <= scaled_o;
            end else if (scaled_o < `WRAP_OUTPUT_HYSTERESIS_LSBS && diff > (`FULL_TURN_MAX - `WRAP_OUTPUT_HYSTERESIS_LSBS)) begin
                scaled_o <= scaled_o;
            end else begin
                scaled_o <= diff;
            end
        end
    end
endmodule

// >>> rtl/encoder_regs.v
`timescale 1ns/1ns
`include "encoder_regs_defs.vh"

// What this block does
// R1 - Serial data and clock pins ignore spikes shorter than 50 ns.
// R2 - Answers only slave address 0x36; host uses it for all registers.
// R3 - Twelve-bit zero offset at 0x01 high nibble and 0x02 low byte.
// R4 - Host changes config by read, modify, write back.
// R5 - Config registers load from programmed memory at power-up; blanks read zero.
// R6 - Power select bits 1:0: normal or low power one to three.
// R7 - Output hysteresis bits 3:2: off or one to three LSBs.
// R8 - Slow filter bits 9:8 give 16x, 8x, 4x, 2x averaging.
// R9 - Any low-power mode forces the 16x slow filter.
// R10 - Fast filter threshold bits 12:10 map to fixed LSB thresholds.
// R11 - Bit 13 enables automatic entry into deepest low-power mode.
// R12 - Resolution code gives 8 doubling to 1024; others give 2048.
// R13 - Quadrature update rate follows resolution, 61 Hz up to 15.6 kHz.
// R14 - Host sets press threshold at 0x0A to half the gain swing.
// R15 - Raw angle read-only at 0x0C high and 0x0D low.
// R16 - Scaled angle read-only at 0x0E high and 0x0F low.
// R17 - Scaled angle holds a 10 LSB band at the wrap point.
// R18 - Status at 0x0B: present bit 5, weak bit 4, strong bit 3.
// R19 - Strong flag set when gain reaches its minimum.
// R20 - Weak flag set when gain reaches its maximum.
// R21 - Gain level at 0x1A, magnitude at 0x1B and 0x1C, read-only.
// R22 - Read-only burn count at 0x00 counts zero-offset commits.
// R23 - Writing 0x80 to 0xFF commits zero offset, three times, magnet present.
// R24 - Writing 0x40 to 0xFF commits configuration once only.
// R25 - Reads at angle or magnitude high byte do not advance the pointer.
// R26 - Unmapped reads return zero; pointer still advances and wraps.
module encoder_regs #(
    parameter GAIN_MIN = 8'h00,
    parameter GAIN_MAX = 8'hFF
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // I2C pins
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    // Programmed memory contents, valid at power-up
    input  wire [11:0] otp_zero_i,
    input  wire [13:0] otp_config_i,
    input  wire [3:0]  otp_quad_i,
    input  wire [7:0]  otp_press_i,
    input  wire [1:0]  otp_burn_count_i,
    input  wire        otp_config_done_i,
    // Measurement inputs
    input  wire [11:0] raw_angle_i,
    input  wire [7:0]  gain_level_i,
    input  wire [11:0] magnitude_i,
    input  wire        magnet_present_i,
    // Decoded settings
    output reg  [1:0]  power_select_o,
    output reg         reduced_power_state_o,
    output reg  [1:0]  output_hysteresis_o,
    output reg  [4:0]  slow_filter_avg_o,
    output reg  [4:0]  fast_filter_thresh_o,
    output reg         auto_sleep_enable_o,
    output reg  [11:0] quad_positions_o,
    output reg  [7:0]  press_threshold_o,
    output reg  [11:0] scaled_angle_o,
    // Programming strobes
    output reg         commit_zero_o,
    output reg         commit_config_o
);
    // ********
    // Pin filtering and bus events
    // ********
    wire       scl_f;
    wire       sda_f;
    wire [11:0] scaled_w;
    reg        scl_q;
    reg        sda_q;

    spike_filter #(.SPIKE_NS(`SPIKE_NS), .CLK_NS(`CLK_NS)) u_scl (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (scl_i),
        .level_o (scl_f)
    );
    spike_filter #(.SPIKE_NS(`SPIKE_NS), .CLK_NS(`CLK_NS)) u_sda (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (sda_i),
        .level_o (sda_f)
    );

    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire start_ev = scl_f & scl_q & sda_q & ~sda_f;
    wire stop_ev  = scl_f & scl_q & ~sda_q & sda_f;

    // ********
    // Register storage
    // ********
    reg [11:0] zero_offset_q;
    reg [13:0] config_word_q;
    reg [3:0]  quad_resolution_q;
    reg [7:0]  press_threshold_q;
    reg [1:0]  zero_burn_count_q;
    reg        config_burnt_q;
    reg        loaded_q;

    // ********
    // Bus slave state
    // ********
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_AACK = 3'h2;
    localparam [2:0] ST_WBYT = 3'h3;
    localparam [2:0] ST_WACK = 3'h4;
    localparam [2:0] ST_RBYT = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg       ptr_loaded_q;
    reg       read_q;
    reg       ack_q;

    function is_valid;
        input [7:0] a;
        begin
            case (a)
                `ADDR_BURN_COUNT, `ADDR_ZERO_HI, `ADDR_ZERO_LO, `ADDR_CONFIG_HI, `ADDR_CONFIG_LO,
                `ADDR_QUAD_RES, `ADDR_PRESS_THR, `ADDR_STATUS, `ADDR_RAW_HI, `ADDR_RAW_LO,
                `ADDR_SCALED_HI, `ADDR_SCALED_LO, `ADDR_GAIN, `ADDR_MAG_HI, `ADDR_MAG_LO,
                `ADDR_COMMIT: is_valid = 1'b1;
                default: is_valid = 1'b0;
            endcase
        end
    endfunction

    // Read multiplexer; unmapped words read zero [R26]
    reg [7:0] rdata;
    always @* begin
        rdata = 8'h00;
        case (ptr_q)
            `ADDR_BURN_COUNT: rdata = {6'h00, zero_burn_count_q}; // [R22]
            `ADDR_ZERO_HI:    rdata = {4'h0, zero_offset_q[11:8]}; // [R3]
            `ADDR_ZERO_LO:    rdata = zero_offset_q[7:0];
            `ADDR_CONFIG_HI:  rdata = {2'h0, config_word_q[13:8]};
            `ADDR_CONFIG_LO:  rdata = config_word_q[7:0];
            `ADDR_QUAD_RES:   rdata = {4'h0, quad_resolution_q};
            `ADDR_PRESS_THR:  rdata = press_threshold_q;
            `ADDR_STATUS:     rdata = {2'h0, magnet_present_i, gain_level_i == GAIN_MAX,
                                       gain_level_i == GAIN_MIN, 3'h0}; // [R18] [R19] [R20]
            `ADDR_RAW_HI:     rdata = {4'h0, raw_angle_i[11:8]}; // [R15]
            `ADDR_RAW_LO:     rdata = raw_angle_i[7:0];
            `ADDR_SCALED_HI:  rdata = {4'h0, scaled_w[11:8]}; // [R16]
            `ADDR_SCALED_LO:  rdata = scaled_w[7:0];
            `ADDR_GAIN:       rdata = gain_level_i; // [R21]
            `ADDR_MAG_HI:     rdata = {4'h0, magnitude_i[11:8]};
            `ADDR_MAG_LO:     rdata = magnitude_i[7:0];
            default:          rdata = 8'h00;
        endcase
    end

    // Pointer holds on the high byte of the live values [R25]
    wire ptr_hold = (ptr_q == `ADDR_RAW_HI) || (ptr_q == `ADDR_SCALED_HI) || (ptr_q == `ADDR_MAG_HI);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q         <= 1'b1;
            sda_q         <= 1'b1;
            state_q       <= ST_IDLE;
            bit_q         <= 4'h0;
            shift_q       <= 8'h00;
            ptr_q         <= 8'h00;
            ptr_loaded_q  <= 1'b0;
            read_q        <= 1'b0;
            ack_q         <= 1'b0;
            sda_o         <= 1'b0;
            sda_oe_o      <= 1'b0;
            zero_offset_q     <= 12'h000;
            config_word_q     <= 14'h0000;
            quad_resolution_q <= 4'h0;
            press_threshold_q <= 8'h00;
            zero_burn_count_q <= 2'h0;
            config_burnt_q    <= 1'b0;
            loaded_q          <= 1'b0;
            commit_zero_o     <= 1'b0;
            commit_config_o   <= 1'b0;
        end else begin
            scl_q           <= scl_f;
            sda_q           <= sda_f;
            commit_zero_o   <= 1'b0;
            commit_config_o <= 1'b0;
            // Memory image taken once after reset; blanks read zero [R5]
            if (!loaded_q) begin
                loaded_q          <= 1'b1;
                zero_offset_q     <= otp_zero_i;
                config_word_q     <= otp_config_i;
                quad_resolution_q <= otp_quad_i;
                press_threshold_q <= otp_press_i;
                zero_burn_count_q <= otp_burn_count_i;
                config_burnt_q    <= otp_config_done_i;
            end
            if (start_ev) begin
                state_q  <= ST_ADDR;
                bit_q    <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_ev) begin
                state_q  <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_ADDR, ST_WBYT: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_f};
                            bit_q   <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (state_q == ST_ADDR) begin
                                // Only our own address is acknowledged [R2]
                                if (shift_q[7:1] == `SLAVE_ADDR) begin
                                    read_q       <= shift_q[0];
                                    ptr_loaded_q <= 1'b0;
                                    sda_o        <= 1'b0;
                                    sda_oe_o     <= 1'b1;
                                    state_q      <= ST_AACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                // Invalid words are refused and the pointer moves on [R26]
                                if (!ptr_loaded_q) begin
                                    ptr_q        <= shift_q;
                                    ptr_loaded_q <= 1'b1;
                                    ack_q        <= is_valid(shift_q);
                                    sda_oe_o     <= is_valid(shift_q);
                                end else begin
                                    sda_oe_o <= is_valid(ptr_q);
                                    ptr_q    <= ptr_q + 8'h01;
                                    case (ptr_q)
                                        `ADDR_ZERO_HI:   zero_offset_q[11:8]  <= shift_q[3:0];
                                        `ADDR_ZERO_LO:   zero_offset_q[7:0]   <= shift_q;
                                        `ADDR_CONFIG_HI: config_word_q[13:8]  <= shift_q[5:0];
                                        `ADDR_CONFIG_LO: config_word_q[7:0]   <= shift_q;
                                        `ADDR_QUAD_RES:  quad_resolution_q    <= shift_q[3:0];
                                        `ADDR_PRESS_THR: press_threshold_q    <= shift_q;
                                        `ADDR_COMMIT: begin
                                            // Zero commit: magnet present and fewer than three done [R23]
                                            if (shift_q == `CMD_COMMIT_ZERO && magnet_present_i &&
                                                zero_burn_count_q != `MAX_ZERO_COMMITS) begin
                                                zero_burn_count_q <= zero_burn_count_q + 2'h1;
                                                commit_zero_o     <= 1'b1;
                                            end
                                            // Config commit allowed once [R24]
                                            if (shift_q == `CMD_COMMIT_CONFIG && !config_burnt_q) begin
                                                config_burnt_q  <= 1'b1;
                                                commit_config_o <= 1'b1;
                                            end
                                        end
                                        default: ;
                                    endcase
                                end
                                sda_o   <= 1'b0;
                                state_q <= ST_WACK;
                            end
                        end
                    end
                    ST_AACK, ST_WACK: begin
                        if (scl_fall) begin
                            if (read_q && state_q == ST_AACK) begin
                                shift_q  <= rdata;
                                sda_o    <= rdata[7];
                                sda_oe_o <= ~rdata[7];
                                bit_q    <= 4'h1;
                                state_q  <= ST_RBYT;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state_q  <= ST_WBYT;
                            end
                        end
                    end
                    ST_RBYT: begin
                        // Open drain: drive only the low bits
                        if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                state_q  <= ST_RACK;
                                if (!ptr_hold) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end else begin
                                sda_oe_o <= ~shift_q[7 - bit_q[2:0]];
                                bit_q    <= bit_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            ack_q <= ~sda_f;
                        end else if (scl_fall) begin
                            if (ack_q) begin
                                shift_q  <= rdata;
                                sda_oe_o <= ~rdata[7];
                                bit_q    <= 4'h1;
                                state_q  <= ST_RBYT;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ********
    // Setting decode
    // ********
    angle_scaler u_scale (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .raw_i    (raw_angle_i),
        .offset_i (zero_offset_q),
        .scaled_o (scaled_w)
    );

    wire [1:0] pm = config_word_q[`POWER_LSB+1:`POWER_LSB];
    wire [1:0] sf = config_word_q[`SLOW_LSB+1:`SLOW_LSB];

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_select_o        <= 2'h0;
            reduced_power_state_o <= 1'b0;
            output_hysteresis_o   <= 2'h0;
            slow_filter_avg_o     <= 5'h10;
            fast_filter_thresh_o  <= 5'h00;
            auto_sleep_enable_o   <= 1'b0;
            quad_positions_o      <= 12'h008;
            press_threshold_o     <= 8'h00;
            scaled_angle_o        <= 12'h000;
        end else begin
            power_select_o        <= pm; // [R6]
            reduced_power_state_o <= (pm != 2'h0);
            output_hysteresis_o   <= config_word_q[`OUTPUT_HYSTERESIS_LSB+1:`OUTPUT_HYSTERESIS_LSB]; // [R7]
            // Low power forces the longest average [R9]
            if (pm != 2'h0) begin
                slow_filter_avg_o <= 5'h10;
            end else begin
                slow_filter_avg_o <= 5'h10 >> sf; // [R8]
            end
            case (config_word_q[`FAST_LSB+2:`FAST_LSB]) // [R10]
                3'h1:    fast_filter_thresh_o <= 5'h06;
                3'h2:    fast_filter_thresh_o <= 5'h07;
                3'h3:    fast_filter_thresh_o <= 5'h09;
                3'h4:    fast_filter_thresh_o <= 5'h12;
                3'h5:    fast_filter_thresh_o <= 5'h15;
                3'h6:    fast_filter_thresh_o <= 5'h18;
                3'h7:    fast_filter_thresh_o <= 5'h0A;
                default: fast_filter_thresh_o <= 5'h00;
            endcase
            auto_sleep_enable_o <= config_word_q[`AUTO_SLEEP_BIT]; // [R11]
            // Update rate doubles with positions, so one code drives both [R12] [R13]
            if (quad_resolution_q[3]) begin
                quad_positions_o <= 12'h800;
            end else begin
                quad_positions_o <= 12'h008 << quad_resolution_q[2:0];
            end
            press_threshold_o <= press_threshold_q;
            scaled_angle_o    <= scaled_w;
        end
    end
endmodule

// >>> rtl/encoder_regs_defs.vh
`ifndef ENCODER_REGS_DEFS_VH
`define ENCODER_REGS_DEFS_VH

// ********
// Bus address and register offsets
// ********
`define SLAVE_ADDR 7'h36
`define ADDR_BURN_COUNT 8'h00
`define ADDR_ZERO_HI 8'h01
`define ADDR_ZERO_LO 8'h02
`define ADDR_CONFIG_HI 8'h07
`define ADDR_CONFIG_LO 8'h08
`define ADDR_QUAD_RES 8'h09
`define ADDR_PRESS_THR 8'h0A
`define ADDR_STATUS 8'h0B
`define ADDR_RAW_HI 8'h0C
`define ADDR_RAW_LO 8'h0D
`define ADDR_SCALED_HI 8'h0E
`define ADDR_SCALED_LO 8'h0F
`define ADDR_GAIN 8'h1A
`define ADDR_MAG_HI 8'h1B
`define ADDR_MAG_LO 8'h1C
`define ADDR_COMMIT 8'hFF

// ********
// Commands and field positions
// ********
`define CMD_COMMIT_ZERO 8'h80
`define CMD_COMMIT_CONFIG 8'h40
`define MAX_ZERO_COMMITS 2'h3
`define POWER_LSB 0
`define OUTPUT_HYSTERESIS_LSB 2
`define SLOW_LSB 8
`define FAST_LSB 10
`define AUTO_SLEEP_BIT 13
`define WRAP_OUTPUT_HYSTERESIS_LSBS 12'h00A
`define FULL_TURN_MAX 12'hFFF

// ********
// Timing
// ********
`define SPIKE_NS 50
`define CLK_NS 50

`endif

// >>> rtl/spike_filter.v
`timescale 1ns/1ns
// Two-flop synchroniser followed by a stability filter
module spike_filter #(
    parameter SPIKE_NS = 50,
    parameter CLK_NS   = 50
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Pin and filtered level
    input  wire pin_i,
    output reg  level_o
);
    // Least time rounds up; at least one cycle of stability
    localparam integer CNT = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam integer TOP = (CNT < 1) ? 1 : CNT;
    reg       meta_q;
    reg       sync_q;
    reg [3:0] stable_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q   <= 1'b1;
            sync_q   <= 1'b1;
            stable_q <= 4'h0;
            level_o  <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            // A new level must hold longer than a spike before it counts [R1]
            if (sync_q == level_o) begin
                stable_q <= 4'h0;
            end else if (stable_q >= TOP[3:0]) begin
                level_o  <= sync_q;
                stable_q <= 4'h0;
            end else begin
                stable_q <= stable_q + 4'h1;
            end
        end
    end
endmodule

// >>> testbench/encoder_regs_chk.sv
`timescale 1ns/1ns
module encoder_regs_chk (
    // Clock and reset
    input logic        clk_i,
    input logic        rst_i,
    // Watched ports
    input logic        scl_i,
    input logic        sda_oe_o,
    input logic        magnet_present_i,
    input logic [1:0]  otp_burn_count_i,
    input logic        otp_config_done_i,
    input logic [1:0]  power_select_o,
    input logic        reduced_power_state_o,
    input logic [4:0]  slow_filter_avg_o,
    input logic [4:0]  fast_filter_thresh_o,
    input logic [11:0] quad_positions_o,
    input logic        commit_zero_o,
    input logic        commit_config_o
);
    // ********
    // Commit history
    // ********
    logic [2:0] zero_cnt_q;
    logic       cfg_done_q;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            zero_cnt_q <= 3'h0;
            cfg_done_q <= 1'b0;
        end else begin
            zero_cnt_q <= zero_cnt_q + {2'h0, commit_zero_o};
            cfg_done_q <= cfg_done_q | commit_config_o;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ********
    // Properties
    // ********
    a_sda_steady: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("sda moved");
    a_power_flag: assert property (reduced_power_state_o == (power_select_o != 2'h0)) else $error("power");
    a_slow_forced: assert property (reduced_power_state_o |-> slow_filter_avg_o == 5'h10) else $error("slow");
    a_slow_codes: assert property (slow_filter_avg_o inside {5'h10, 5'h08, 5'h04, 5'h02}) else $error("avg");
    a_fast_codes: assert property (fast_filter_thresh_o inside {5'h00, 5'h06, 5'h07, 5'h09, 5'h12, 5'h15,
        5'h18, 5'h0A}) else $error("fast");
    a_quad_codes: assert property ($onehot(quad_positions_o) && quad_positions_o >= 12'h008) else $error("quad");
    a_zero_magnet: assert property (commit_zero_o |-> magnet_present_i) else $error("no magnet");
    a_zero_limit: assert property (commit_zero_o |-> zero_cnt_q + otp_burn_count_i < 3'h3) else $error("burns");
    a_config_once: assert property (commit_config_o |-> !cfg_done_q && !otp_config_done_i) else $error("cfg");
    a_commit_pulse: assert property (commit_zero_o || commit_config_o |=> !commit_zero_o && !commit_config_o)
        else $error("pulse");
    c_zero: cover property (commit_zero_o);
    c_config: cover property (commit_config_o);
    c_ack: cover property ($rose(sda_oe_o));
endmodule
bind encoder_regs encoder_regs_chk encoder_regs_chk_i (.*);

// >>> testbench/host.sv
`timescale 1ns/1ns
module host (
    // Clock and bus lines
    input  logic clk_i,
    input  logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // ********
    // Six-cycle phases, so each level outlasts the pin filters
    // ********
    initial {scl_o, sda_low_o} = 2'b10;
    task ph(input logic c, input logic l);
        repeat (6) @(negedge clk_i);
        scl_o = c;
        sda_low_o = l;
    endtask
    // l low gives a start, l high a stop
    task cond(input logic l);
        ph(1'b0, sda_low_o);
        ph(1'b0, l);
        ph(1'b1, l);
        ph(1'b1, !l);
    endtask
    task bitx(input logic b, output logic r);
        ph(1'b0, sda_low_o);
        ph(1'b0, !b);
        ph(1'b1, !b);
        ph(1'b1, !b);
        r = sda_i;
    endtask
    task xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ai, ao);
    endtask
    task addr(input logic rd, output logic ack);
        logic [7:0] q;
        xfer({7'h36, rd}, 1'b1, q, ack);
    endtask
endmodule

// >>> testbench/test_rotary_encoder_register_bank.sv
`timescale 1ns/1ns
module test_rotary_encoder_register_bank;
    // ********
    // Stimulus, wiring and bookkeeping
    // ********
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        present = 1'b1;
    logic [7:0]  gain = 8'h80;
    logic [11:0] raw = 12'hABC;
    logic [13:0] cfg = 14'h2D0E;
    logic [7:0]  q [0:15];
    logic        pa;
    logic [4:0]  fast_filter_thresh [0:7] = '{5'h00, 5'h06, 5'h07, 5'h09, 5'h12, 5'h15, 5'h18, 5'h0A};
    int          n_mismatch = 0, num_checks = 0, nz = 0, nc = 0;
    wire         scl, sda_low, sda_o, oe, red, aut, cz, cc;
    wire         sda = ~(oe | sda_low);
    wire  [1:0]  pwr, hys;
    wire  [4:0]  slow, fast;
    wire  [7:0]  prs;
    wire  [11:0] quad, scal;
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) nz += (cz === 1'b1);
    always @(posedge clk_i) nc += (cc === 1'b1);
    host host_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    encoder_regs encoder_regs_i (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(oe), .otp_zero_i(12'h5A3), .otp_config_i(cfg), .otp_quad_i(4'h6), .otp_press_i(8'h44),
        .otp_burn_count_i(2'h1), .otp_config_done_i(1'b0), .raw_angle_i(raw), .gain_level_i(gain),
        .magnitude_i(raw), .magnet_present_i(present), .power_select_o(pwr), .reduced_power_state_o(red),
        .output_hysteresis_o(hys), .slow_filter_avg_o(slow), .fast_filter_thresh_o(fast),
        .auto_sleep_enable_o(aut), .quad_positions_o(quad), .press_threshold_o(prs), .scaled_angle_o(scal),
        .commit_zero_o(cz), .commit_config_o(cc));
    task chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] p, input logic [7:0] d, input bit w = 1'b1);
        logic a;
        logic [7:0] r;
        host_i.cond(1'b0);
        host_i.addr(1'b0, a);
        host_i.xfer(p, 1'b1, r, pa);
        if (w) host_i.xfer(d, 1'b1, r, a);
        host_i.cond(1'b1);
    endtask
    task rd(input logic [7:0] p, input int n);
        logic a;
        wr(p, 8'h00, 1'b0);
        host_i.cond(1'b0);
        host_i.addr(1'b1, a);
        chk(a, 1'b0);
        for (int i = 0; i < n; i++) host_i.xfer(8'hFF, i == n - 1, q[i], a);
        host_i.cond(1'b1);
    endtask
    // ********
    // Scenarios
    // ********
    task t_power_up;
        logic [7:0] e [0:10] = '{8'h01, 8'h05, 8'hA3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2D, 8'h0E, 8'h06, 8'h44};
        chk({sda_o, aut, fast, slow, pwr, hys, quad, prs}, {1'b0, 1'b1, 5'h09, 5'h10, 2'h2, 2'h3, 12'h200, 8'h44});
        host_i.cond(1'b0);
        host_i.addr(1'b1, pa);
        for (int i = 0; i < 11; i++) host_i.xfer(8'hFF, i == 10, q[i], pa);
        host_i.cond(1'b1);
        for (int i = 0; i < 11; i++) chk(q[i], e[i]);
    endtask
    task t_config;
        rd(8'h08, 1);
        for (int p = 3; p >= 0; p--) begin
            wr(8'h08, {q[0][7:4], p[1:0], p[1:0]});
            chk({pwr, hys, red, slow}, {p[1:0], p[1:0], p != 0, p != 0 ? 5'h10 : 5'h08});
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h07, {2'h0, i[0], i[2:0], i[1:0]});
            chk({aut, fast, slow}, {i[0], fast_filter_thresh[i], 5'h10 >> i[1:0]});
        end
        for (int c = 0; c < 10; c++) begin
            wr(8'h09, c[7:0]);
            chk(quad, c < 8 ? 12'h008 << c : 12'h800);
        end
    endtask
    task t_angles;
        rd(8'h0C, 3);
        chk({q[0], q[1], q[2], scal}, {24'h0A_0A0A, 12'h519});
        wr(8'h02, 8'hBC);
        rd(8'h0E, 2);
        chk({q[0], q[1], scal}, {16'h0505, 12'h500});
        raw = 12'h5B7;
        repeat (3) @(negedge clk_i);
        raw = 12'h5C0;
        rd(8'h0E, 1);
        chk({q[0], scal}, {8'h0F, 12'hFFB});
    endtask
    task t_status;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_i);
            present = k != 2;
            gain = k == 0 ? 8'h00 : {k[0], 7'h7F};
            rd(8'h0B, 1);
            chk(q[0], {2'h0, k != 2, k == 1, k == 0, 3'h0});
        end
        rd(8'h1A, 1);
        chk(q[0], 8'h7F);
        rd(8'h1B, 2);
        chk({q[0], q[1]}, 16'h0505);
        wr(8'h0A, (8'hFF - 8'h7F) >> 1);
        chk(prs, 8'h40);
    endtask
    // Magnet absent on entry: first zero commit is dropped
    task t_commit;
        wr(8'h03, 8'h55);
        chk(pa, 1'b1);
        wr(8'h00, 8'h03);
        wr(8'hFF, 8'h80);
        @(negedge clk_i);
        present = 1'b1;
        repeat (3) wr(8'hFF, 8'h80);
        repeat (2) wr(8'hFF, 8'h40);
        rd(8'h00, 1);
        chk({nz[3:0], nc[3:0], q[0]}, 16'h2103);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_power_up;
        t_config;
        t_angles;
        t_status;
        t_commit;
        end_of_test;
    end
    // Margin over the expected run
    initial begin
        #4_000_000;
        n_mismatch++;
        end_of_test;
    end
endmodule
